// ===== src/wbr_cfg.svh
// Constants for the work bit delay and event routing block
// Assumes a 20 MHz system clock and an Avalon-MM register master
`ifndef WBR_CFG_SVH
`define WBR_CFG_SVH

`define WBR_CLK_HZ         20000000
`define WBR_DELAY_MAX      14'h270F
`define WBR_DELAY_RST      14'h0000
`define WBR_WB_COUNT       8
`define WBR_EV_COUNT       6
`define WBR_EXT_COUNT      6
`define WBR_SRC_NONE       4'h0
`define WBR_SRC_WB_BASE    4'h7
`define WBR_SRC_MAX        4'hE
`define WBR_SEC_CYCLES     32'h01312D00
`define WBR_SEC_PER_MIN    6'h3C
// Register word offsets (byte address = 4 * index)
`define WBR_ADDR_CTRL      4'h0
`define WBR_ADDR_OPTYPE    4'h1
`define WBR_ADDR_INVERT    4'h2
`define WBR_ADDR_DELAY_SEL 4'h3
`define WBR_ADDR_ON_DLY    4'h4
`define WBR_ADDR_OFF_DLY   4'h5
`define WBR_ADDR_EV_SRC    4'h6
`define WBR_ADDR_EV_FUNC   4'h7
`define WBR_ADDR_OUT_SEL   4'h8
`define WBR_ADDR_PW_STORE  4'h9
`define WBR_ADDR_PW_ENTRY  4'hA
`define WBR_ADDR_PROTECT   4'hB
`define WBR_ADDR_STATUS    4'hC
`define WBR_ADDR_EV_SRC2   4'hD
// Event function code meaning communications write enable/disable
`define WBR_FUNC_COMM_WE   4'hF
`define WBR_BAD_READ       32'hDEADBEEF

`endif

// ===== src/wbr_pkg.sv
// Types for the work bit delay and event routing block
// Shared by the top module and its submodules
package wbr_pkg;

	typedef enum logic [4:0] {
		WBR_OP_OFF = 5'b00001,
		WBR_OP_AB_OR_CD = 5'b00010,
		WBR_OP_AC_AND_BD = 5'b00100,
		WBR_OP_ANY = 5'b01000,
		WBR_OP_ALL = 5'b10000
	} wbr_op_type;

	typedef enum logic [1:0] {
		WBR_DLY_IDLE = 2'b01,
		WBR_DLY_RUN = 2'b10
	} wbr_dly_state_type;

endpackage

// ===== src/wbr_time_base.sv
// Seconds time base: one-cycle ticks every second and every minute
// Assumes sys_clk_i at 20 MHz
`timescale 1ns/1ps
`include "wbr_cfg.svh"

module wbr_time_base (
	input  wire logic sys_clk_i,
	input  wire logic rst_n_i,
	output logic      sec_tick_o,
	output logic      min_tick_o
);
	import wbr_pkg::*;

	typedef struct packed {
		logic [31:0] cyc;
		logic [5:0]  sec;
		logic        s_tick;
		logic        m_tick;
	} wbr_tb_state_type;

	wbr_tb_state_type st_reg;
	wbr_tb_state_type st_next;

	always_comb begin
		st_next = st_reg;
		st_next.s_tick = 1'b0;
		st_next.m_tick = 1'b0;
		if (st_reg.cyc == `WBR_SEC_CYCLES - 32'd1) begin
			st_next.cyc = 32'd0;
			st_next.s_tick = 1'b1;
			if (st_reg.sec == `WBR_SEC_PER_MIN - 6'd1) begin
				st_next.sec = 6'd0;
				st_next.m_tick = 1'b1;
			end else begin
				st_next.sec = st_reg.sec + 6'd1;
			end
		end else begin
			st_next.cyc = st_reg.cyc + 32'd1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sec_tick_o = st_reg.s_tick;
	assign min_tick_o = st_reg.m_tick;

endmodule

// ===== src/wbr_delay.sv
// One work bit: ON/OFF delay filter driven by a unit tick
// Assumes level_i is synchronous to sys_clk_i
`timescale 1ns/1ps
`include "wbr_cfg.svh"

module wbr_delay (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        level_i,
	input  wire logic        tick_i,
	input  wire logic [13:0] on_dly_i,
	input  wire logic [13:0] off_dly_i,
	output logic             out_o
);
	import wbr_pkg::*;

	typedef struct packed {
		wbr_dly_state_type fsm;
		logic [13:0]       cnt;
		logic              out;
	} wbr_dly_type;

	wbr_dly_type st_reg;
	wbr_dly_type st_next;
	logic [13:0] dly;

	assign dly = level_i ? on_dly_i : off_dly_i;

	always_comb begin
		st_next = st_reg;
		unique case (st_reg.fsm)
			WBR_DLY_IDLE: begin
				if (level_i != st_reg.out) begin
					if (dly == 14'd0) begin
						st_next.out = level_i;
					end else begin
						st_next.fsm = WBR_DLY_RUN;
						st_next.cnt = 14'd0;
					end
				end
			end
			WBR_DLY_RUN: begin
				if (level_i == st_reg.out) begin
					st_next.fsm = WBR_DLY_IDLE;
				end else if (tick_i) begin
					if (st_reg.cnt + 14'd1 >= dly) begin
						st_next.out = level_i;
						st_next.fsm = WBR_DLY_IDLE;
					end else begin
						st_next.cnt = st_reg.cnt + 14'd1;
					end
				end
			end
			default: st_next.fsm = WBR_DLY_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			st_reg <= '{fsm: WBR_DLY_IDLE, cnt: 14'd0, out: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign out_o = st_reg.out;

	dly_no_early_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(st_reg.fsm == WBR_DLY_RUN && !tick_i) |=> $stable(out_o))
		else $error("delayed output changed without tick");
	// zero delay follows in one cycle
	dly_zero_follow_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(st_reg.fsm == WBR_DLY_IDLE && dly == 14'd0 && level_i != out_o)
		|=> out_o == $past(level_i))
		else $error("zero delay did not follow");
endmodule

// ===== src/wbr_top.sv
// Work bit logic, ON/OFF delays, event routing and front-panel protect gating
// Assumes an Avalon-MM master on sys_clk_i; event pins are asynchronous
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "wbr_cfg.svh"

// Overview of operation
// - Output turns off at the OFF delay-th unit tick after the change; the first unit may be partial.
// - OFF delay accepts 0 to 9999, resets to 0, 0 disables it.
// - One unit select picks seconds or minutes, seconds after reset.
// - Delay settings editable from menu whenever operation type is not off; writes also need op guard 0 or a matched password.
// - Event source: 0 none, 1-6 external inputs, 7-14 work bits.
// - Source selects editable without terminals; changed default shows assignment menu.
// - Work bit sourced event refuses communications write enable function.
// - Work bit on control or auxiliary output marks alarms 1-4 assigned.
// - Each work bit may be inverted, normally closed instead of open.
// - Protected parameters hidden, yet their stored settings still apply.
// - Protect level entry prompt offered only with nonzero stored password.
// - Matching password reveals the operation/adjustment guard setting.
// - Four independent protect categories restrict front-panel keys differently.
// - Output turns on only after ON delay 0-9999, 0 disables.
// - Work bit combines four inputs by one chosen operation.
module wbr_top (
	input  wire logic                  sys_clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic [3:0]            avs_address_i,
	input  wire logic                  avs_read_i,
	input  wire logic                  avs_write_i,
	input  wire logic [31:0]           avs_writedata_i,
	output logic      [31:0]           avs_readdata_o,
	output logic                       avs_waitrequest_o,
	input  wire logic [5:0]            ext_event_i,
	input  wire logic [8*4*5-1:0]      wb_inputs_i,
	output logic      [5:0]            internal_event_o,
	output logic      [7:0]            work_bit_o,
	output logic                       alarms_assigned_o,
	output logic                       delay_menu_visible_o,
	output logic                       event_menu_visible_o,
	output logic                       protect_level_entry_prompt_o,
	output logic                       operation_adjustment_guard_visible_o,
	output logic                       key_change_allowed_o,
	output logic                       func_key_enabled_o
);
	import wbr_pkg::*;

	typedef struct packed {
		logic [39:0]  op;
		logic [31:0]  in_inv;
		logic [7:0]   wb_inv;
		logic         unit_min;
		logic [2:0]   dly_sel;
		logic [111:0] on_dly;
		logic [111:0] off_dly;
		logic [23:0]  ev_src;
		logic [23:0]  ev_func;
		logic [7:0]   out_wb;
		logic [15:0]  pw_store;
		logic         pw_ok;
		logic [1:0]   op_guard;
		logic [1:0]   init_guard;
		logic         change_guard;
		logic         fkey_guard;
		logic         ev_changed;
		logic [5:0]   ext_s1;
		logic [5:0]   ext_s2;
		logic [7:0]   comb_q;
		logic [31:0]  rdata;
		logic         ack;
	} wbr_state_type;

	wbr_state_type st_reg;
	wbr_state_type st_next;

	logic       sec_tick;
	logic       min_tick;
	logic       unit_tick;
	logic [7:0] comb_raw;
	logic [7:0] wb_delayed;
	logic [7:0] wb_final;
	logic [7:0] op_active;
	logic [5:0] ev_from_wb;
	logic [5:0] ev_level;
	logic       sel_event_accept;
	logic [3:0] new_src;
	logic [3:0] new_func;

	wbr_time_base u_tb (
		.sys_clk_i  (sys_clk_i),
		.rst_n_i    (rst_n_i),
		.sec_tick_o (sec_tick),
		.min_tick_o (min_tick)
	);

	assign unit_tick = st_reg.unit_min ? min_tick : sec_tick;

	genvar g;
	generate
		for (g = 0; g < `WBR_WB_COUNT; g++) begin : g_wb
			logic [3:0] inp;
			logic [4:0] op_code;
			logic       res;
			assign inp = wb_inputs_i[g*20 +: 4] ^ st_reg.in_inv[g*4 +: 4];
			assign op_code = st_reg.op[g*5 +: 5];
			assign op_active[g] = op_code != WBR_OP_OFF;
			always_comb begin
				unique case (op_code)
					WBR_OP_AB_OR_CD: res = (inp[0] & inp[1]) | (inp[2] & inp[3]);
					WBR_OP_AC_AND_BD: res = (inp[0] | inp[2]) & (inp[1] | inp[3]);
					WBR_OP_ANY: res = |inp;
					WBR_OP_ALL: res = &inp;
					default: res = 1'b0;
				endcase
			end
			assign comb_raw[g] = res;
			wbr_delay u_dly (
				.sys_clk_i (sys_clk_i),
				.rst_n_i   (rst_n_i),
				.level_i   (st_reg.comb_q[g]),
				.tick_i    (unit_tick),
				.on_dly_i  (st_reg.on_dly[g*14 +: 14]),
				.off_dly_i (st_reg.off_dly[g*14 +: 14]),
				.out_o     (wb_delayed[g])
			);
			assign wb_final[g] = wb_delayed[g] ^ st_reg.wb_inv[g];
		end
		for (g = 0; g < `WBR_EV_COUNT; g++) begin : g_ev
			logic [3:0] src;
			logic       lvl;
			logic       from_wb;
			assign src = st_reg.ev_src[g*4 +: 4];
			always_comb begin
				lvl = 1'b0;
				from_wb = 1'b0;
				if (src >= `WBR_SRC_WB_BASE && src <= `WBR_SRC_MAX) begin
					lvl = wb_final[3'(src - `WBR_SRC_WB_BASE)];
					from_wb = 1'b1;
				end else if (src != `WBR_SRC_NONE) begin
					lvl = st_reg.ext_s2[3'(src - 4'd1)];
				end
			end
			assign ev_level[g] = lvl;
			assign ev_from_wb[g] = from_wb;
		end
	endgenerate

	assign new_src = avs_writedata_i[3:0];
	assign new_func = avs_writedata_i[3:0];
	assign sel_event_accept = !(new_func == `WBR_FUNC_COMM_WE
		&& ev_from_wb[st_reg.dly_sel < 3'd6 ? st_reg.dly_sel : 3'd0]);

	always_comb begin
		st_next = st_reg;
		st_next.ext_s1 = ext_event_i;
		st_next.ext_s2 = st_reg.ext_s1;
		st_next.comb_q = comb_raw;
		st_next.ack = 1'b0;
		if ((avs_read_i || avs_write_i) && !st_reg.ack) begin
			st_next.ack = 1'b1;
		end
		begin
			// Write lands only at the edge where waitrequest is seen low
			if (avs_write_i && st_reg.ack) begin
				unique case (avs_address_i)
					`WBR_ADDR_CTRL: st_next.unit_min = avs_writedata_i[0];
					`WBR_ADDR_OPTYPE: st_next.op[st_reg.dly_sel*5 +: 5] = avs_writedata_i[4:0];
					`WBR_ADDR_INVERT: begin
						st_next.in_inv = avs_writedata_i[31:0];
						st_next.wb_inv = avs_writedata_i[7:0];
					end
					`WBR_ADDR_DELAY_SEL: st_next.dly_sel = avs_writedata_i[2:0];
					`WBR_ADDR_ON_DLY: begin
						if (op_active[st_reg.dly_sel] && avs_writedata_i[13:0] <= `WBR_DELAY_MAX
							&& (st_reg.op_guard < 2'd1 || st_reg.pw_ok)) begin
							st_next.on_dly[st_reg.dly_sel*14 +: 14] = avs_writedata_i[13:0];
						end
					end
					`WBR_ADDR_OFF_DLY: begin
						if (op_active[st_reg.dly_sel] && avs_writedata_i[13:0] <= `WBR_DELAY_MAX
							&& (st_reg.op_guard < 2'd1 || st_reg.pw_ok)) begin
							st_next.off_dly[st_reg.dly_sel*14 +: 14] = avs_writedata_i[13:0];
						end
					end
					`WBR_ADDR_EV_SRC: begin
						if (st_reg.dly_sel < 3'd6 && new_src <= `WBR_SRC_MAX) begin
							st_next.ev_src[st_reg.dly_sel*4 +: 4] = new_src;
							st_next.ev_changed = st_reg.ev_changed | (new_src != `WBR_SRC_NONE);
						end
					end
					`WBR_ADDR_EV_FUNC: begin
						if (st_reg.dly_sel < 3'd6 && sel_event_accept) begin
							st_next.ev_func[st_reg.dly_sel*4 +: 4] = new_func;
						end
					end
					`WBR_ADDR_OUT_SEL: st_next.out_wb = avs_writedata_i[7:0];
					`WBR_ADDR_PW_STORE: st_next.pw_store = avs_writedata_i[15:0];
					`WBR_ADDR_PW_ENTRY: st_next.pw_ok = st_reg.pw_store != 16'h0000
						&& avs_writedata_i[15:0] == st_reg.pw_store;
					`WBR_ADDR_PROTECT: begin
						if (st_reg.pw_ok) begin
							st_next.op_guard = avs_writedata_i[1:0];
						end
						st_next.init_guard = avs_writedata_i[5:4];
						st_next.change_guard = avs_writedata_i[8];
						st_next.fkey_guard = avs_writedata_i[12];
					end
					default: ;
				endcase
			end
			// Read data is latched at request, stands while waitrequest is low
			if (avs_read_i && !st_reg.ack) begin
				unique case (avs_address_i)
					`WBR_ADDR_CTRL: st_next.rdata = {31'd0, st_reg.unit_min};
					`WBR_ADDR_OPTYPE: st_next.rdata = {27'd0, st_reg.op[st_reg.dly_sel*5 +: 5]};
					`WBR_ADDR_INVERT: st_next.rdata = st_reg.in_inv;
					`WBR_ADDR_DELAY_SEL: st_next.rdata = {29'd0, st_reg.dly_sel};
					`WBR_ADDR_ON_DLY: st_next.rdata = {18'd0, st_reg.on_dly[st_reg.dly_sel*14 +: 14]};
					`WBR_ADDR_OFF_DLY: st_next.rdata = {18'd0, st_reg.off_dly[st_reg.dly_sel*14 +: 14]};
					`WBR_ADDR_EV_SRC: st_next.rdata = {8'd0, st_reg.ev_src};
					`WBR_ADDR_EV_FUNC: st_next.rdata = {8'd0, st_reg.ev_func};
					`WBR_ADDR_OUT_SEL: st_next.rdata = {24'd0, st_reg.out_wb};
					`WBR_ADDR_PW_STORE: st_next.rdata = {31'd0, st_reg.pw_store != 16'h0000};
					`WBR_ADDR_PW_ENTRY: st_next.rdata = {31'd0, st_reg.pw_ok};
					`WBR_ADDR_PROTECT: st_next.rdata = {19'd0, st_reg.fkey_guard, 3'd0,
						st_reg.change_guard, 2'd0, st_reg.init_guard, 2'd0,
						st_reg.pw_ok ? st_reg.op_guard : 2'd0};
					`WBR_ADDR_STATUS: st_next.rdata = {2'd0, internal_event_o, wb_final,
						op_active, 8'd0};
					default: st_next.rdata = `WBR_BAD_READ;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
			st_reg.op <= {8{WBR_OP_OFF}};
		end else begin
			st_reg <= st_next;
		end
	end

	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !st_reg.ack;
	assign avs_readdata_o = st_reg.rdata;
	assign internal_event_o = ev_level;
	assign work_bit_o = wb_final;
	assign alarms_assigned_o = |st_reg.out_wb;
	// Delay menu needs an active operation type, event menu a changed source; they hide at op guard nonzero and init guard 2, settings still apply
	assign delay_menu_visible_o = (|op_active) && st_reg.op_guard == 2'd0;
	assign event_menu_visible_o = st_reg.ev_changed && st_reg.init_guard != 2'd2;
	assign protect_level_entry_prompt_o = st_reg.pw_store != 16'h0000;
	assign operation_adjustment_guard_visible_o = st_reg.pw_ok;
	assign key_change_allowed_o = !st_reg.change_guard;
	assign func_key_enabled_o = !st_reg.fkey_guard;

	prompt_pw_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(avs_write_i && st_reg.ack && avs_address_i == `WBR_ADDR_PW_STORE)
		|=> protect_level_entry_prompt_o == ($past(avs_writedata_i[15:0]) != 16'h0000))
		else $error("prompt mismatch");
	alarm_route_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(avs_write_i && st_reg.ack && avs_address_i == `WBR_ADDR_OUT_SEL
		&& avs_writedata_i[7:0] != 8'h00) |=> alarms_assigned_o)
		else $error("alarms not marked");
	comm_refuse_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(avs_write_i && st_reg.ack && avs_address_i == `WBR_ADDR_EV_FUNC && !sel_event_accept)
		|=> $stable(st_reg.ev_func))
		else $error("comm write enable accepted");
	pw_mismatch_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(avs_write_i && st_reg.ack && avs_address_i == `WBR_ADDR_PW_ENTRY
		&& avs_writedata_i[15:0] != st_reg.pw_store) |=> !operation_adjustment_guard_visible_o)
		else $error("guard shown on mismatch");
	ev_route_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(st_reg.ev_src[23:20] == 4'h7) |-> internal_event_o[5] == work_bit_o[0])
		else $error("event 6 not from work bit 1");
	wb_invert_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$stable(wb_delayed)
		|-> (work_bit_o ^ $past(work_bit_o)) == (st_reg.wb_inv ^ $past(st_reg.wb_inv)))
		else $error("inversion wrong");
	dly_blocked_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(avs_write_i && st_reg.ack && avs_address_i == `WBR_ADDR_OFF_DLY
		&& !op_active[st_reg.dly_sel]) |=> $stable(st_reg.off_dly))
		else $error("delay changed while off");
	// Bus answers after one wait cycle
	bus_answer_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(avs_read_i && avs_waitrequest_o) |=> !avs_waitrequest_o)
		else $error("no answer");
endmodule

// ===== tb/wbr_field.sv
// Far-side model: event input contacts and work bit condition levels
// Assumes the bench sets the wanted levels; the model moves them on a clock edge
`timescale 1ns/1ps

module wbr_field (
	input  wire logic         sys_clk_i,
	input  wire logic [5:0]   contact_i,
	input  wire logic [159:0] cond_i,
	output logic      [5:0]   ext_event_o,
	output logic      [159:0] wb_inputs_o
);
	initial begin
		ext_event_o = 6'h00;
		wb_inputs_o = '0;
	end

	// Contacts change only just after a rising edge, like a real slow switch
	always @(posedge sys_clk_i) begin
		ext_event_o <= contact_i;
		wb_inputs_o <= cond_i;
	end
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the work bit delay and event routing block
// Assumes one 20 MHz clock; registers reached over Avalon-MM with waitrequest
`timescale 1ns/1ps
`include "wbr_cfg.svh"

module tb_top;
	import wbr_pkg::*;
	logic         sys_clk;
	logic         rst_n;
	logic         rd;
	logic         wr;
	logic [3:0]   addr;
	logic [31:0]  wdata;
	logic [31:0]  rdat;
	logic [31:0]  rdata;
	logic         waitreq;
	logic [5:0]   contact;
	logic [159:0] cond;
	logic [5:0]   ext_ev;
	logic [159:0] wb_in;
	logic [5:0]   iev;
	logic [7:0]   work_bit;
	logic         alarms;
	logic         dmenu;
	logic         emenu;
	logic         prompt;
	logic         guard;
	logic         kchg;
	logic         fkey;
	int           failures;
	int           n_checks;
	int           k;
	wbr_op_type   op_t[10] = '{WBR_OP_AB_OR_CD, WBR_OP_AB_OR_CD, WBR_OP_AC_AND_BD,
		WBR_OP_AC_AND_BD, WBR_OP_ANY, WBR_OP_ANY, WBR_OP_ALL, WBR_OP_ALL, WBR_OP_OFF, WBR_OP_OFF};
	logic [3:0]   pat_t[10] = '{4'hC, 4'h5, 4'h5, 4'h3, 4'h4, 4'h0, 4'hF, 4'h7, 4'hF, 4'h0};
	logic         exp_t[10] = '{1, 0, 0, 1, 1, 0, 1, 0, 0, 0};

	wbr_field i_field (
		.sys_clk_i   (sys_clk),
		.contact_i   (contact),
		.cond_i      (cond),
		.ext_event_o (ext_ev),
		.wb_inputs_o (wb_in)
	);

	wbr_top i_dut (
		.sys_clk_i                            (sys_clk),
		.rst_n_i                              (rst_n),
		.avs_address_i                        (addr),
		.avs_read_i                           (rd),
		.avs_write_i                          (wr),
		.avs_writedata_i                      (wdata),
		.avs_readdata_o                       (rdat),
		.avs_waitrequest_o                    (waitreq),
		.ext_event_i                          (ext_ev),
		.wb_inputs_i                          (wb_in),
		.internal_event_o                     (iev),
		.work_bit_o                           (work_bit),
		.alarms_assigned_o                    (alarms),
		.delay_menu_visible_o                 (dmenu),
		.event_menu_visible_o                 (emenu),
		.protect_level_entry_prompt_o         (prompt),
		.operation_adjustment_guard_visible_o (guard),
		.key_change_allowed_o                 (kchg),
		.func_key_enabled_o                   (fkey)
	);

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic summarize();
		$display("checks %0d, mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// One Avalon-MM access; held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		// Answer is looked at settled, as it stands for the coming rising edge
		for (i = 0; i < 50; i++) begin
			@(negedge sys_clk);
			if (waitreq === 1'b0) break;
		end
		rdata = rdat;
		@(posedge sys_clk);
		wr <= 1'b0;
		rd <= 1'b0;
		if (i == 50) begin
			failures++;
			$display("unexpected at %0t: bus access hung", $time);
			summarize();
		end
	endtask

	initial begin
		rst_n = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = 4'h0;
		wdata = 32'h0000_0000;
		contact = 6'h00;
		cond = '0;
		failures = 0;
		n_checks = 0;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		idle(2);
		check({kchg, fkey, prompt, guard, alarms, dmenu, emenu}, 7'h60, "reset levels");
		check({work_bit, iev}, 32'h0, "reset outputs");
		$display("test reset done");

		bus(1'b1, `WBR_ADDR_DELAY_SEL, 32'h0);
		for (k = 0; k < 10; k++) begin
			bus(1'b1, `WBR_ADDR_OPTYPE, {27'h0, op_t[k]});
			cond[3:0] <= pat_t[k];
			idle(6);
			check(work_bit[0], exp_t[k], "operation result");
			check(dmenu, op_t[k] != WBR_OP_OFF, "delay menu");
		end
		$display("test operations done");

		bus(1'b1, `WBR_ADDR_OPTYPE, {27'h0, WBR_OP_ANY});
		bus(1'b1, `WBR_ADDR_ON_DLY, 32'h1);
		cond[0] <= 1'b1;
		idle(2000);
		check(work_bit[0], 1'b0, "on delay held");
		cond[0] <= 1'b0;
		idle(6);
		check(work_bit[0], 1'b0, "short pulse");
		bus(1'b1, `WBR_ADDR_ON_DLY, 32'h0);
		bus(1'b1, `WBR_ADDR_ON_DLY, 32'd10000);
		cond[0] <= 1'b1;
		idle(6);
		check(work_bit[0], 1'b1, "zero delay kept");
		bus(1'b1, `WBR_ADDR_OFF_DLY, 32'h1);
		cond[0] <= 1'b0;
		idle(2000);
		check(work_bit[0], 1'b1, "off delay held");
		$display("test delays done");

		contact <= 6'h25;
		for (k = 0; k < 6; k++) begin
			bus(1'b1, `WBR_ADDR_DELAY_SEL, k);
			bus(1'b1, `WBR_ADDR_EV_SRC, k + 1);
		end
		idle(6);
		check(iev, 6'h25, "external routing");
		check(emenu, 1'b1, "event menu");
		bus(1'b1, `WBR_ADDR_DELAY_SEL, 32'h5);
		bus(1'b1, `WBR_ADDR_EV_SRC, 32'h7);
		bus(1'b1, `WBR_ADDR_DELAY_SEL, 32'h0);
		bus(1'b1, `WBR_ADDR_EV_SRC, 32'h0);
		bus(1'b1, `WBR_ADDR_DELAY_SEL, 32'h2);
		bus(1'b1, `WBR_ADDR_EV_SRC, 32'hE);
		bus(1'b1, `WBR_ADDR_DELAY_SEL, 32'h3);
		bus(1'b1, `WBR_ADDR_EV_SRC, 32'hF);
		contact <= 6'h1A;
		idle(6);
		check(iev, 6'h3A, "mixed routing");
		bus(1'b1, `WBR_ADDR_DELAY_SEL, 32'h5);
		bus(1'b1, `WBR_ADDR_EV_FUNC, 32'hF);
		bus(1'b1, `WBR_ADDR_DELAY_SEL, 32'h1);
		bus(1'b1, `WBR_ADDR_EV_FUNC, 32'hF);
		bus(1'b0, `WBR_ADDR_EV_FUNC, 32'h0);
		check(rdata, 32'h0000_00F0, "comm write refused");
		$display("test events done");

		bus(1'b1, `WBR_ADDR_OUT_SEL, 32'h1);
		idle(3);
		check(alarms, 1'b1, "alarms assigned");
		bus(1'b1, `WBR_ADDR_OUT_SEL, 32'h0);
		idle(3);
		check(alarms, 1'b0, "alarms released");
		$display("test outputs done");

		bus(1'b1, `WBR_ADDR_PW_STORE, 32'd1234);
		idle(3);
		check(prompt, 1'b1, "entry prompt");
		bus(1'b1, `WBR_ADDR_PW_ENTRY, 32'd1);
		idle(3);
		check(guard, 1'b0, "wrong password");
		bus(1'b1, `WBR_ADDR_PW_ENTRY, 32'd1234);
		idle(3);
		check(guard, 1'b1, "right password");
		bus(1'b1, `WBR_ADDR_PROTECT, 32'h100);
		idle(3);
		check({kchg, fkey}, 2'b01, "change protect");
		bus(1'b1, `WBR_ADDR_PROTECT, 32'h1001);
		idle(3);
		check({kchg, fkey}, 2'b10, "key protect");
		check(dmenu, 1'b0, "menu hidden by guard");
		bus(1'b0, `WBR_ADDR_STATUS, 32'h0);
		check(rdata[29:16], {6'h3A, 8'h01}, "settings still act");
		bus(1'b1, `WBR_ADDR_PW_STORE, 32'h0);
		idle(3);
		check(prompt, 1'b0, "prompt hidden");
		bus(1'b0, 4'hF, 32'h0);
		check(rdata, `WBR_BAD_READ, "unmapped read");
		bus(1'b1, `WBR_ADDR_INVERT, 32'h80);
		idle(3);
		check(work_bit[7], 1'b1, "normally closed");
		$display("test protect done");
		summarize();
	end
endmodule
